/* File: asfs_asserts.sv */
// concurrent checks on the spi wire between host end and sensor end
`timescale 1ns/1ps
`default_nettype none
module asfs_asserts (
  input wire logic clock,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  logic [4:0] cnt_r;
  logic sclk_q_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclk_q_r <= 1'b1;
    end else begin
      sclk_q_r <= sclk;
    end
  end
  // rising serial clock edges seen inside the current frame
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r <= 5'h00;
    end else if (cs_n) begin
      cnt_r <= 5'h00;
    end else if (sclk && !sclk_q_r) begin
      cnt_r <= cnt_r + 5'h01;
    end
  end
  a_idle_clk_high: assert property (cs_n |-> sclk)
    else $error("sclk low while deselected");
  a_select_setup: assert property ($fell(cs_n) |-> sclk [*4] ##1 !sclk)
    else $error("first sclk fall not four cycles after select");
  a_low_half: assert property ($fell(sclk) |-> !sclk [*4] ##1 sclk)
    else $error("sclk low phase not four cycles");
  a_high_half: assert property ($rose(sclk) && !cs_n |-> sclk [*4])
    else $error("sclk high phase too short");
  a_mosi_held: assert property ($rose(sclk) && !cs_n |=> $stable(mosi) [*3])
    else $error("mosi moved around rising sclk");
  a_miso_held: assert property ($rose(sclk) && !cs_n |=> $stable(miso) [*3])
    else $error("miso moved around rising sclk");
  a_frame_len: assert property ($rose(cs_n) |-> cnt_r inside {5'h10, 5'h11, 5'h14})
    else $error("frame length not 16, 17 or 20");
  a_idle_gap: assert property ($rose(cs_n) |-> cs_n [*2])
    else $error("select idle time too short");
  c_frame_16: cover property ($rose(cs_n) && cnt_r == 5'h10);
  c_frame_17: cover property ($rose(cs_n) && cnt_r == 5'h11);
  c_frame_20: cover property ($rose(cs_n) && cnt_r == 5'h14);
endmodule : asfs_asserts
`default_nettype wire

/* File: asfs_dev.sv */
// sensor end: spi mode 3 target framing, pipelined reads, crc out
`timescale 1ns/1ps
`default_nettype none
`include "asfs_regs.svh"
module asfs_dev
  import asfs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  asfs_if.dev link,
  input wire logic long_frame_enable,
  input wire asfs_word_t rd_data,
  output logic [5:0] rd_addr,
  output logic wr_stb,
  output logic [5:0] wr_addr,
  output logic [7:0] wr_data,
  output logic ier_flag,
  input wire logic ier_clr
);
  logic [1:0] sclk_s_r, cs_s_r, mosi_s_r;
  logic sclk_d_r, cs_d_r;
  logic [4:0] cnt_r;
  logic [15:0] sh_in_r;
  logic [19:0] sh_out_r;
  logic [5:0] rd_addr_r;
  logic wr_stb_r;
  logic [5:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic ier_r;
  logic miso_r;
  asfs_word_t result;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise, sel;
  logic len_ok, is_write, frame_ok, extra_clk;

  // frame lengths accepted at release of select
  function automatic logic asfs_len_valid(input logic [4:0] n, input logic en);
    return (n == `ASFS_LEN_SHORT) || (n == `ASFS_LEN_CRC) || (n == `ASFS_LEN_LONG && en);
  endfunction : asfs_len_valid

  // register address field of a received command word
  function automatic logic [5:0] asfs_cmd_addr(input logic [15:0] w);
    return w[`ASFS_ADDR_HI:`ASFS_ADDR_LO];
  endfunction : asfs_cmd_addr

  // each pin passes two flops; the delayed copy finds edges
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclk_s_r <= 2'h3;
      sclk_d_r <= 1'b1;
    end else begin
      sclk_s_r <= {sclk_s_r[0], link.sclk};
      sclk_d_r <= sclk_s_r[1];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cs_s_r <= 2'h3;
      cs_d_r <= 1'b1;
    end else begin
      cs_s_r <= {cs_s_r[0], link.cs_n};
      cs_d_r <= cs_s_r[1];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mosi_s_r <= 2'h0;
    end else begin
      mosi_s_r <= {mosi_s_r[0], link.mosi};
    end
  end

  // idle-high reset values keep a false edge from following reset
  assign sel = ~cs_s_r[1];
  assign sclk_rise = sel & sclk_s_r[1] & ~sclk_d_r;
  assign sclk_fall = sel & ~sclk_s_r[1] & sclk_d_r;
  assign cs_fall = ~cs_s_r[1] & cs_d_r;
  assign cs_rise = cs_s_r[1] & ~cs_d_r;

  // odd address returns one byte, register zero reads all zero
  always_comb begin
    if (rd_addr_r == `ASFS_ZERO_ADDR) begin
      result = `ASFS_ZERO_DATA;
    end else if (rd_addr_r[0]) begin
      result = {8'h00, rd_data[7:0]};
    end else begin
      result = rd_data;
    end
  end
  assign rd_addr = {rd_addr_r[5:1], 1'b0};

  // bit counter; it saturates so runaway frames still read as too long
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r <= 5'h00;
    end else if (cs_fall) begin
      cnt_r <= 5'h00;
    end else if (sclk_rise && cnt_r != 5'h1f) begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  // input shifter keeps the first sixteen bits of the frame
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sh_in_r <= 16'h0000;
    end else if (cs_fall) begin
      sh_in_r <= 16'h0000;
    end else if (sclk_rise && cnt_r < `ASFS_LEN_SHORT) begin
      sh_in_r <= {sh_in_r[14:0], mosi_s_r[1]};
    end
  end

  // output shifter: previous result then crc, moves on falling edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sh_out_r <= 20'h00000;
    end else if (cs_fall) begin
      sh_out_r <= {result, asfs_crc16(result)};
    end else if (sclk_fall && cnt_r != 5'h00) begin
      sh_out_r <= {sh_out_r[18:0], 1'b0};
    end
  end

  // the first falling edge keeps bit 15 up; later ones step the word
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      miso_r <= 1'b0;
    end else if (cs_fall) begin
      miso_r <= result[15];
    end else if (sclk_fall && cnt_r != 5'h00) begin
      miso_r <= sh_out_r[18];
    end
  end
  assign link.miso = miso_r;

  assign len_ok = asfs_len_valid(cnt_r, long_frame_enable);
  assign frame_ok = cs_rise & len_ok & ~sh_in_r[`ASFS_BIT_START];
  assign extra_clk = cs_rise & ~len_ok & (cnt_r > `ASFS_LEN_SHORT);
  assign is_write = ~sh_in_r[`ASFS_BIT_START] & sh_in_r[`ASFS_BIT_RW];

  // write capture at frame end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_stb_r <= 1'b0;
      wr_addr_r <= 6'h00;
      wr_data_r <= 8'h00;
    end else begin
      wr_stb_r <= frame_ok & is_write;
      if (frame_ok && is_write) begin
        wr_addr_r <= asfs_cmd_addr(sh_in_r);
        wr_data_r <= sh_in_r[7:0];
      end
    end
  end

  // read address for the next frame; a write points it at register zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_addr_r <= 6'h00;
    end else if (frame_ok) begin
      if (is_write) begin
        rd_addr_r <= `ASFS_ZERO_ADDR;
      end else begin
        rd_addr_r <= asfs_cmd_addr(sh_in_r);
      end
    end
  end
  assign wr_stb = wr_stb_r;
  assign wr_addr = wr_addr_r;
  assign wr_data = wr_data_r;

  // sticky extra-clock warning, set wins over clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ier_r <= 1'b0;
    end else if (extra_clk) begin
      ier_r <= 1'b1;
    end else if (ier_clr) begin
      ier_r <= 1'b0;
    end
  end
  assign ier_flag = ier_r;
endmodule : asfs_dev
`default_nettype wire

/* File: asfs_host.sv */
// host end: spi mode 3 controller issuing one frame per request
`timescale 1ns/1ps
`default_nettype none
`include "asfs_regs.svh"
module asfs_host
  import asfs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  asfs_if.host link,
  input wire logic req,
  input wire logic req_write,
  input wire logic [5:0] req_addr,
  input wire logic [7:0] req_data,
  input wire logic [4:0] req_len,
  output logic busy,
  output logic done,
  output asfs_word_t rsp_data,
  output logic [3:0] rsp_crc,
  output logic rsp_valid,
  output logic rsp_crc_ok
);
  asfs_hstate_t st_r;
  logic [3:0] div_r;
  logic sclk_r, cs_r, mosi_r;
  logic [4:0] len_r, cnt_r;
  logic [19:0] tx_r, rx_r, rx_nxt;
  logic [1:0] miso_s_r;
  logic prev_rd_r, this_rd_r;
  logic done_r, valid_r, crc_ok_r;
  asfs_word_t data_r;
  logic [3:0] crc_r;
  logic [15:0] cmd;

  assign cmd = {1'b0, req_write, req_addr, req_write ? req_data : 8'h00};
  // sampled at the end of each high half: the sensor's sync delay
  // puts its new bit out too late for the rising edge itself
  assign rx_nxt = {rx_r[18:0], miso_s_r[1]};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      miso_s_r <= 2'h0;
    end else begin
      miso_s_r <= {miso_s_r[0], link.miso};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= ASFS_IDLE;
      div_r <= 4'h0;
      sclk_r <= 1'b1;
      cs_r <= 1'b1;
      mosi_r <= 1'b0;
      len_r <= 5'h00;
      cnt_r <= 5'h00;
      tx_r <= 20'h00000;
      rx_r <= 20'h00000;
      prev_rd_r <= 1'b0;
      this_rd_r <= 1'b0;
      done_r <= 1'b0;
      valid_r <= 1'b0;
      crc_ok_r <= 1'b0;
      data_r <= 16'h0000;
      crc_r <= 4'h0;
    end else begin
      done_r <= 1'b0;
      case (st_r)
        ASFS_IDLE: begin
          sclk_r <= 1'b1;
          if (req) begin
            len_r <= req_len;
            tx_r <= {cmd, asfs_crc16(cmd)};
            this_rd_r <= ~req_write;
            cs_r <= 1'b0;
            div_r <= 4'h0;
            cnt_r <= 5'h00;
            st_r <= ASFS_ASSERT;
          end
        end
        ASFS_ASSERT: begin
          div_r <= div_r + 4'h1;
          if (div_r == `ASFS_SCLK_DIV - 4'h1) begin
            div_r <= 4'h0;
            sclk_r <= 1'b0;
            mosi_r <= tx_r[19];
            tx_r <= {tx_r[18:0], 1'b0};
            st_r <= ASFS_SHIFT;
          end
        end
        ASFS_SHIFT: begin
          div_r <= div_r + 4'h1;
          if (div_r == `ASFS_SCLK_DIV - 4'h1) begin
            div_r <= 4'h0;
            if (!sclk_r) begin
              sclk_r <= 1'b1;
              cnt_r <= cnt_r + 5'h01;
              if (cnt_r + 5'h01 == len_r) begin
                st_r <= ASFS_DONE;
              end
            end else begin
              sclk_r <= 1'b0;
              rx_r <= rx_nxt;
              mosi_r <= tx_r[19];
              tx_r <= {tx_r[18:0], 1'b0};
            end
          end
        end
        ASFS_DONE: begin
          div_r <= div_r + 4'h1;
          if (div_r == `ASFS_SCLK_DIV - 4'h1) begin
            cs_r <= 1'b1;
            done_r <= 1'b1;
            rx_r <= rx_nxt;
            valid_r <= prev_rd_r;
            prev_rd_r <= this_rd_r;
            if (len_r == `ASFS_LEN_CRC) begin
              data_r <= rx_nxt[19:4];
              crc_r <= rx_nxt[3:0];
              crc_ok_r <= asfs_crc16(rx_nxt[19:4]) == rx_nxt[3:0];
            end else begin
              data_r <= (len_r == `ASFS_LEN_LONG) ? rx_nxt[16:1] : rx_nxt[15:0];
              crc_r <= 4'h0;
              crc_ok_r <= 1'b0;
            end
            st_r <= ASFS_IDLE;
          end
        end
        default: st_r <= ASFS_IDLE;
      endcase
    end
  end

  assign link.sclk = sclk_r;
  assign link.cs_n = cs_r;
  assign link.mosi = mosi_r;
  assign busy = (st_r != ASFS_IDLE);
  assign done = done_r;
  assign rsp_data = data_r;
  assign rsp_crc = crc_r;
  assign rsp_valid = valid_r;
  assign rsp_crc_ok = crc_ok_r;
endmodule : asfs_host
`default_nettype wire

/* File: asfs_if.sv */
// spi link between the host end and the sensor end
`timescale 1ns/1ps
`default_nettype none
interface asfs_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport host (output sclk, output cs_n, output mosi, input miso);
  modport dev (input sclk, input cs_n, input mosi, output miso);
endinterface : asfs_if
`default_nettype wire

/* File: asfs_pkg.sv */
// types shared by both ends of the spi framing link
package asfs_pkg;
  typedef enum logic [1:0] {ASFS_IDLE, ASFS_ASSERT, ASFS_SHIFT, ASFS_DONE} asfs_hstate_t;
  typedef logic [15:0] asfs_word_t;
  // crc x^4+x+1, one bit step
  function automatic logic [3:0] asfs_crc_step(input logic [3:0] c, input logic d);
    logic inv;
    inv = d ^ c[3];
    asfs_crc_step = {c[2], c[1], c[0] ^ inv, inv};
  endfunction : asfs_crc_step
  function automatic logic [3:0] asfs_crc16(input logic [15:0] w);
    logic [3:0] c;
    c = 4'hf;
    for (int i = 15; i >= 0; i--) begin
      c = asfs_crc_step(c, w[i]);
    end
    asfs_crc16 = c;
  endfunction : asfs_crc16
endpackage : asfs_pkg

/* File: asfs_regs.svh */
// constants for the angle sensor spi framing link
`ifndef ASFS_REGS_SVH
`define ASFS_REGS_SVH
`define ASFS_LEN_SHORT 5'd16
`define ASFS_LEN_LONG 5'd17
`define ASFS_LEN_CRC 5'd20
`define ASFS_CRC_PRESET 4'hf
`define ASFS_BIT_START 15
`define ASFS_BIT_RW 14
`define ASFS_ADDR_HI 13
`define ASFS_ADDR_LO 8
`define ASFS_ZERO_ADDR 6'h00
`define ASFS_ZERO_DATA 16'h0000
`define ASFS_SCLK_DIV 4'd4
`endif

/* File: tb.sv */
// testbench joining host end and sensor end over the spi link
`timescale 1ns/1ps
`default_nettype none
module tb
  import asfs_pkg::*;
;
  logic clock, rst, req, req_write, busy, done, rsp_valid, rsp_crc_ok;
  logic [5:0] req_addr, rd_addr, wr_addr;
  logic [7:0] req_data, wr_data;
  logic [4:0] req_len;
  logic [3:0] rsp_crc;
  asfs_word_t rsp_data, rd_data;
  logic long_frame_enable, wr_stb, ier_flag, ier_clr;
  int n_fail, checks, n_wr, cyc;
  asfs_if link();
  asfs_host u_asfs_host (.clock(clock), .rst(rst), .link(link), .req(req),
    .req_write(req_write), .req_addr(req_addr), .req_data(req_data), .req_len(req_len),
    .busy(busy), .done(done), .rsp_data(rsp_data), .rsp_crc(rsp_crc),
    .rsp_valid(rsp_valid), .rsp_crc_ok(rsp_crc_ok));
  asfs_dev u_asfs_dev (.clock(clock), .rst(rst), .link(link),
    .long_frame_enable(long_frame_enable), .rd_data(rd_data), .rd_addr(rd_addr),
    .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data), .ier_flag(ier_flag),
    .ier_clr(ier_clr));
  asfs_asserts u_chk (.clock(clock), .rst(rst), .sclk(link.sclk), .cs_n(link.cs_n),
    .mosi(link.mosi), .miso(link.miso));
  function automatic logic [15:0] word(input logic [5:0] a);
    return {2'h1, a, 2'h3, a};
  endfunction : word
  function automatic logic [3:0] crc_of(input logic [15:0] w);
    logic [3:0] c;
    logic inv;
    c = 4'hf;
    for (int i = 15; i >= 0; i--) begin
      inv = w[i] ^ c[3];
      c = {c[2], c[1], c[0] ^ inv, inv};
    end
    return c;
  endfunction : crc_of
  // register file stand-in, nonzero even at word zero
  assign rd_data = word(rd_addr);
  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task stop_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  task frame(input logic w, input logic [5:0] a, input logic [7:0] d, input logic [4:0] n);
    @(posedge clock);
    req <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_data <= d;
    req_len <= n;
    @(posedge clock);
    req <= 1'b0;
    for (int i = 0; i < 400 && done !== 1'b1; i++) @(posedge clock);
    chk("done", done, 1'b1);
    repeat (6) @(posedge clock);
  endtask : frame
  task t_write;
    frame(1'b1, 6'h04, 8'ha5, 5'h10);
    chk("wr_addr", wr_addr, 6'h04);
    chk("wr_data", wr_data, 8'ha5);
    chk("rsp_valid", rsp_valid, 1'b0);
    frame(1'b1, 6'h05, 8'h3c, 5'h14);
    chk("wr_data", wr_data, 8'h3c);
    chk("wr_count", 16'(n_wr), 16'h0002);
    chk("ier_flag", ier_flag, 1'b0);
    $display("t_write done");
  endtask : t_write
  task t_read;
    frame(1'b0, 6'h20, 8'h00, 5'h10);
    frame(1'b0, 6'h21, 8'h00, 5'h14);
    chk("rsp_data", rsp_data, word(6'h20));
    chk("rsp_valid", rsp_valid, 1'b1);
    chk("rsp_crc", rsp_crc, crc_of(word(6'h20)));
    chk("rsp_crc_ok", rsp_crc_ok, 1'b1);
    frame(1'b0, 6'h00, 8'h00, 5'h10);
    chk("rsp_odd", rsp_data, word(6'h20) & 16'h00ff);
    frame(1'b0, 6'h00, 8'h00, 5'h14);
    chk("rsp_zero", rsp_data, 16'h0000);
    chk("rsp_crc", rsp_crc, crc_of(16'h0000));
    chk("wr_count", 16'(n_wr), 16'h0002);
    chk("ier_flag", ier_flag, 1'b0);
    $display("t_read done");
  endtask : t_read
  task t_long;
    long_frame_enable <= 1'b1;
    frame(1'b0, 6'h20, 8'h00, 5'h11);
    chk("ier_flag", ier_flag, 1'b0);
    frame(1'b0, 6'h00, 8'h00, 5'h11);
    chk("rsp_long", rsp_data, word(6'h20));
    long_frame_enable <= 1'b0;
    frame(1'b0, 6'h00, 8'h00, 5'h11);
    chk("ier_set", ier_flag, 1'b1);
    ier_clr <= 1'b1;
    @(posedge clock);
    ier_clr <= 1'b0;
    repeat (2) @(posedge clock);
    chk("ier_clr", ier_flag, 1'b0);
    $display("t_long done");
  endtask : t_long
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    if (wr_stb === 1'b1) n_wr++;
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    {rst, req, req_write, req_addr, req_data} = {2'h2, 15'h0000};
    {req_len, long_frame_enable, ier_clr} = 7'h40;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_write();
    t_read();
    t_long();
    stop_test();
  end
endmodule : tb
`default_nettype wire
